// ### logic/power_event_consts.vh
// Constants for the power event interrupt enable block.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses.
`ifndef POWER_EVENT_CONSTS_VH
`define POWER_EVENT_CONSTS_VH

// ***************************************
// Register offsets
// ***************************************
`define EVENT_SLEEP_ENTRY_OFFSET 12'h114
`define EVENT_SLEEP_EXIT_OFFSET 12'h118
`define EVENT_SUPPLY_DETECTED_OFFSET 12'h11C
`define EVENT_SUPPLY_REMOVED_OFFSET 12'h120
`define EVENT_REGULATOR_READY_OFFSET 12'h124
`define EVENT_SUPPLY_WARNING_OFFSET 12'h108
`define INTERRUPT_ENABLE_SET_OFFSET 12'h304
`define INTERRUPT_ENABLE_CLEAR_OFFSET 12'h308

// ***************************************
// Field positions
// ***************************************
`define FIELD_SUPPLY_WARNING 5'h02
`define FIELD_SLEEP_ENTRY 5'h05
`define FIELD_SLEEP_EXIT 5'h06
`define FIELD_SUPPLY_DETECTED 5'h07
`define FIELD_SUPPLY_REMOVED 5'h08
`define FIELD_REGULATOR_READY 5'h09
`define EVENT_COUNT 6

// ***************************************
// Reset values and answers
// ***************************************
`define ENABLE_RESET 6'h00
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ### logic/event_flag.v
// One sticky event flag with write-one-to-clear.
// Assumes the event input is already in the core_clk domain.
`timescale 1ns/1ps
module event_flag (
   input wire core_clk,
   input wire srst,
   input wire eventIn,
   input wire clearIn,
   output reg flagOut
);
   // Set wins over a clear in the same cycle so no event is lost
   always @(posedge core_clk) begin
      if (srst) begin
         flagOut <= 1'b0;
      end else if (eventIn) begin
         flagOut <= 1'b1;
      end else if (clearIn) begin
         flagOut <= 1'b0;
      end
   end
endmodule

// ### logic/power_event_interrupt_enable.v
// Interrupt enable logic and event flags for six power events.
// Assumes AXI4-Lite master on core_clk; event inputs are asynchronous pins.
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
`include "power_event_consts.vh"

// Summary of operation
// - Enable set register sits at 0x304; writing one turns an enable on.
// - One at supply warning field enables that interrupt, others unchanged.
// - Separate set fields for sleep entry and sleep exit, set by one.
// - Set fields for supply detected, supply removed, regulator ready events.
// - Enable clear register sits at 0x308; writing one turns an enable off.
// - Both registers read back the current enables, one meaning enabled.
// - Sleep entry flag at 0x114 sets when the processor enters sleep.
// - Supply detected flag at 0x11C sets when bus supply appears.
module power_event_interrupt_enable #(
   parameter ADDR_WIDTH = 12
) (
   input wire core_clk,
   input wire srst,
   input wire [ADDR_WIDTH-1:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [ADDR_WIDTH-1:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire supplyFailureWarning,
   input wire cpuSleepEntry,
   input wire cpuSleepExit,
   input wire busSupplyDetected,
   input wire busSupplyRemoved,
   input wire busRegulatorReady,
   output reg irq
);
   localparam N = `EVENT_COUNT;

   // ***************************************
   // Event inputs: sync and edge detect
   // ***************************************
   wire [N-1:0] eventPin;
   reg [N-1:0] syncA_reg;
   reg [N-1:0] syncB_reg;
   reg [N-1:0] syncC_reg;
   wire [N-1:0] eventPulse;
   assign eventPin = {busRegulatorReady, busSupplyRemoved, busSupplyDetected,
                      cpuSleepExit, cpuSleepEntry, supplyFailureWarning};

   always @(posedge core_clk) begin
      if (srst) begin
         syncA_reg <= {N{1'b0}};
         syncB_reg <= {N{1'b0}};
         syncC_reg <= {N{1'b0}};
      end else begin
         syncA_reg <= eventPin;
         syncB_reg <= syncA_reg;
         syncC_reg <= syncB_reg;
      end
   end
   // Rising edge of the synchronised level; first stage stays untouched
   assign eventPulse = syncB_reg & ~syncC_reg;

   // ***************************************
   // Write channel capture
   // ***************************************
   reg [ADDR_WIDTH-1:0] wAddr_reg;
   reg haveAddr_reg;
   reg [31:0] wData_reg;
   reg [3:0] wStrb_reg;
   reg haveData_reg;
   wire awTaken;
   wire wTaken;
   wire doWrite;
   wire [31:0] wMask;
   assign awTaken = s_axi_awvalid && s_axi_awready;
   assign wTaken = s_axi_wvalid && s_axi_wready;
   assign doWrite = haveAddr_reg && haveData_reg && !s_axi_bvalid;
   // Strobes gate whole bytes; fields 8 and 9 need byte 1
   assign wMask = wData_reg & {{8{wStrb_reg[3]}}, {8{wStrb_reg[2]}},
                               {8{wStrb_reg[1]}}, {8{wStrb_reg[0]}}};

   // Readies stay low while a response waits: one write at a time
   always @(posedge core_clk) begin
      if (srst) begin
         haveAddr_reg <= 1'b0;
         wAddr_reg <= {ADDR_WIDTH{1'b0}};
         s_axi_awready <= 1'b0;
      end else begin
         s_axi_awready <= !haveAddr_reg && !s_axi_bvalid && !awTaken;
         if (awTaken) begin
            haveAddr_reg <= 1'b1;
            wAddr_reg <= s_axi_awaddr;
         end else if (doWrite) begin
            haveAddr_reg <= 1'b0;
         end
      end
   end

   always @(posedge core_clk) begin
      if (srst) begin
         haveData_reg <= 1'b0;
         wData_reg <= 32'h00000000;
         wStrb_reg <= 4'h0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_wready <= !haveData_reg && !s_axi_bvalid && !wTaken;
         if (wTaken) begin
            haveData_reg <= 1'b1;
            wData_reg <= s_axi_wdata;
            wStrb_reg <= s_axi_wstrb;
         end else if (doWrite) begin
            haveData_reg <= 1'b0;
         end
      end
   end

   // ***************************************
   // Address decode
   // ***************************************
   function [3:0] decode;
      input [ADDR_WIDTH-1:0] a;
      begin
         case (a)
            `EVENT_SUPPLY_WARNING_OFFSET: decode = 4'h0;
            `EVENT_SLEEP_ENTRY_OFFSET: decode = 4'h1;
            `EVENT_SLEEP_EXIT_OFFSET: decode = 4'h2;
            `EVENT_SUPPLY_DETECTED_OFFSET: decode = 4'h3;
            `EVENT_SUPPLY_REMOVED_OFFSET: decode = 4'h4;
            `EVENT_REGULATOR_READY_OFFSET: decode = 4'h5;
            `INTERRUPT_ENABLE_SET_OFFSET: decode = 4'h6;
            `INTERRUPT_ENABLE_CLEAR_OFFSET: decode = 4'h7;
            default: decode = 4'hF;
         endcase
      end
   endfunction

   wire [3:0] wSel;
   wire [3:0] rSel;
   assign wSel = decode(wAddr_reg);
   assign rSel = decode(s_axi_araddr);

   wire wErr;
   wire rErr;
   // Unmapped addresses answer with an error and change nothing
   assign wErr = (wSel == 4'hF);
   assign rErr = (rSel == 4'hF);

   // ***************************************
   // Field map
   // ***************************************
   // Event index, in eventPin order, to its enable field position
   function [4:0] fieldOf;
      input [31:0] idx;
      begin
         case (idx)
            32'h0: fieldOf = `FIELD_SUPPLY_WARNING;
            32'h1: fieldOf = `FIELD_SLEEP_ENTRY;
            32'h2: fieldOf = `FIELD_SLEEP_EXIT;
            32'h3: fieldOf = `FIELD_SUPPLY_DETECTED;
            32'h4: fieldOf = `FIELD_SUPPLY_REMOVED;
            32'h5: fieldOf = `FIELD_REGULATOR_READY;
            default: fieldOf = 5'h00;
         endcase
      end
   endfunction

   // ***************************************
   // Enable vector
   // ***************************************
   reg [N-1:0] enable_reg;
   reg [N-1:0] enable_next;
   wire [N-1:0] wField;

   always @* begin
      enable_next = enable_reg;
      if (doWrite && wSel == 4'h6) begin
         enable_next = enable_reg | wField;
      end else if (doWrite && wSel == 4'h7) begin
         enable_next = enable_reg & ~wField;
      end
   end

   always @(posedge core_clk) begin
      if (srst) begin
         enable_reg <= `ENABLE_RESET;
      end else begin
         enable_reg <= enable_next;
      end
   end

   // ***************************************
   // Event flags
   // ***************************************
   wire [N-1:0] flag;
   wire [N-1:0] flagClear;
   wire [31:0] enableBit [0:N-1];
   genvar g;
   generate
      for (g = 0; g < N; g = g + 1) begin : flags
         assign wField[g] = wMask[fieldOf(g)];
         assign enableBit[g] = {31'h00000000, enable_reg[g]} << fieldOf(g);
         // Writing one to bit 0 of a flag register clears it
         assign flagClear[g] = doWrite && (wSel == g) && wMask[0];
         event_flag event_flag_inst (
            .core_clk(core_clk),
            .srst(srst),
            .eventIn(eventPulse[g]),
            .clearIn(flagClear[g]),
            .flagOut(flag[g])
         );
      end
   endgenerate

   // Enables placed at their field positions for read-back
   reg [31:0] enableView;
   integer k;
   always @* begin
      enableView = 32'h00000000;
      for (k = 0; k < N; k = k + 1) begin
         enableView = enableView | enableBit[k];
      end
   end

   // Flagged and enabled events drive the interrupt
   wire [N-1:0] pending;
   assign pending = flag & enable_reg;

   // ***************************************
   // Write response
   // ***************************************
   always @(posedge core_clk) begin
      if (srst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
      end else if (doWrite) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wErr ? `RESP_SLVERR : `RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ***************************************
   // Read channel
   // ***************************************
   reg [31:0] rValue;
   always @* begin
      rValue = 32'h00000000;
      case (rSel)
         4'h6, 4'h7: begin
            rValue = enableView;
         end
         4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5: begin
            rValue[0] = flag[rSel[2:0]];
         end
         default: begin
            rValue = 32'h00000000;
         end
      endcase
   end

   wire arTaken;
   assign arTaken = s_axi_arvalid && s_axi_arready;

   // Address refused while read data waits: one read at a time
   always @(posedge core_clk) begin
      if (srst) begin
         s_axi_arready <= 1'b0;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !arTaken;
      end
   end

   always @(posedge core_clk) begin
      if (srst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `RESP_OKAY;
      end else begin
         if (arTaken) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rValue;
            s_axi_rresp <= rErr ? `RESP_SLVERR : `RESP_OKAY;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ***************************************
   // Interrupt output
   // ***************************************
   // Registered for a clean output; costs one cycle of latency
   always @(posedge core_clk) begin
      if (srst) begin
         irq <= 1'b0;
      end else begin
         irq <= |pending;
      end
   end
endmodule

// ### verif/power_event_props.sv
// Bus and interrupt checks on the power event block.
// Bound from the bench top; sees top ports only.
`timescale 1ns/1ps
module power_event_props (
   input wire core_clk,
   input wire srst,
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire irq
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);
   // ***********************
   // Handshake and reset properties
   // ***********************
   write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write answer late");
   read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped");
   rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   bvalid_drop_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write answer repeated");
   aw_refuse_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
      else $error("address taken twice");
   ar_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while busy");
   reset_quiet_a: assert property ($fell(srst) |-> !s_axi_bvalid && !s_axi_rvalid && !irq)
      else $error("outputs active after reset");
endmodule

// ### verif/power_event_interrupt_enable_bench.sv
// Register tests for the power event enable block.
// Assumes the constants header on the include path.
`timescale 1ns/1ps
`include "power_event_consts.vh"
module power_event_interrupt_enable_bench;
   localparam [31:0] ALL_EN = (32'h1 << `FIELD_SUPPLY_WARNING) | (32'h1 << `FIELD_SLEEP_ENTRY) |
      (32'h1 << `FIELD_SLEEP_EXIT) | (32'h1 << `FIELD_SUPPLY_DETECTED) | (32'h1 << `FIELD_SUPPLY_REMOVED) |
      (32'h1 << `FIELD_REGULATOR_READY);
   localparam [11:0] SET = `INTERRUPT_ENABLE_SET_OFFSET;
   localparam [11:0] CLR = `INTERRUPT_ENABLE_CLEAR_OFFSET;
   reg core_clk = 0, srst = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   reg s_axi_arvalid = 0, s_axi_rready = 0, supplyFailureWarning = 0, cpuSleepEntry = 0;
   reg cpuSleepExit = 0, busSupplyDetected = 0, busSupplyRemoved = 0, busRegulatorReady = 0;
   reg [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   reg [31:0] s_axi_wdata = 0, expEn, got;
   reg [3:0] s_axi_wstrb = 4'hF;
   reg [1:0] rsp;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   integer failures = 0, cmp_count = 0, i;
   power_event_interrupt_enable power_event_interrupt_enable_inst (
      .core_clk(core_clk), .srst(srst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .supplyFailureWarning(supplyFailureWarning), .cpuSleepEntry(cpuSleepEntry), .cpuSleepExit(cpuSleepExit),
      .busSupplyDetected(busSupplyDetected), .busSupplyRemoved(busSupplyRemoved),
      .busRegulatorReady(busRegulatorReady), .irq(irq)
   );
   initial forever #10 core_clk = ~core_clk;
   // ***********************
   // Bus tasks
   // ***********************
   task chk(input [31:0] g, input [31:0] e);
      begin
         cmp_count = cmp_count + 1;
         if (g !== e) begin
            failures = failures + 1;
            $display("mismatch at %0t got %h expected %h", $time, g, e);
         end
      end
   endtask
   task wr(input [11:0] a, input [31:0] d, input [1:0] er);
      begin
         s_axi_awaddr <= a;
         s_axi_wdata <= d;
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         s_axi_bready <= 1'b1;
         do begin
            @(posedge core_clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bready && s_axi_bvalid) begin
               s_axi_bready <= 1'b0;
               rsp = s_axi_bresp;
            end
         end while (s_axi_awvalid || s_axi_wvalid || s_axi_bready);
         @(posedge core_clk);
         chk({30'h0, rsp}, {30'h0, er});
      end
   endtask
   task rd(input [11:0] a, input [31:0] e, input [1:0] er);
      begin
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'b1;
         s_axi_rready <= 1'b1;
         do begin
            @(posedge core_clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rready && s_axi_rvalid) begin
               s_axi_rready <= 1'b0;
               rsp = s_axi_rresp;
               got = s_axi_rdata;
            end
         end while (s_axi_arvalid || s_axi_rready);
         @(posedge core_clk);
         chk(got, e);
         chk({30'h0, rsp}, {30'h0, er});
      end
   endtask
   task print_verdict;
      begin
         $display("failures %0d comparisons %0d", failures, cmp_count);
         if (failures == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
         else
            $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   // ***********************
   // Tests
   // ***********************
   initial begin
      repeat (10) @(posedge core_clk);
      srst <= 1'b0;
      @(posedge core_clk);
      rd(SET, 32'h0, `RESP_OKAY);
      rd(CLR, 32'h0, `RESP_OKAY);
      expEn = 0;
      for (i = 0; i < 32; i = i + 1) if (ALL_EN[i]) begin
         wr(SET, 32'h1 << i, `RESP_OKAY);
         expEn = expEn | (32'h1 << i);
         rd(SET, expEn, `RESP_OKAY);
         rd(CLR, expEn, `RESP_OKAY);
      end
      wr(SET, 32'h0, `RESP_OKAY);
      wr(CLR, 32'h0, `RESP_OKAY);
      rd(SET, ALL_EN, `RESP_OKAY);
      for (i = 0; i < 32; i = i + 1) if (ALL_EN[i]) begin
         wr(CLR, 32'h1 << i, `RESP_OKAY);
         expEn = expEn & ~(32'h1 << i);
         rd(CLR, expEn, `RESP_OKAY);
      end
      wr(SET, 32'hFFFFFFFF, `RESP_OKAY);
      rd(SET, ALL_EN, `RESP_OKAY);
      wr(CLR, ALL_EN, `RESP_OKAY);
      // Flag raised while masked must stay quiet
      cpuSleepEntry <= 1'b1;
      repeat (6) @(posedge core_clk);
      chk({31'h0, irq}, 32'h0);
      rd(`EVENT_SLEEP_ENTRY_OFFSET, 32'h1, `RESP_OKAY);
      wr(SET, 32'h1 << `FIELD_SLEEP_ENTRY, `RESP_OKAY);
      repeat (2) @(posedge core_clk);
      chk({31'h0, irq}, 32'h1);
      wr(CLR, 32'h1 << `FIELD_SLEEP_ENTRY, `RESP_OKAY);
      repeat (2) @(posedge core_clk);
      chk({31'h0, irq}, 32'h0);
      busSupplyDetected <= 1'b1;
      repeat (6) @(posedge core_clk);
      rd(`EVENT_SUPPLY_DETECTED_OFFSET, 32'h1, `RESP_OKAY);
      wr(`EVENT_SLEEP_ENTRY_OFFSET, 32'h1, `RESP_OKAY);
      rd(`EVENT_SLEEP_ENTRY_OFFSET, 32'h0, `RESP_OKAY);
      wr(12'h300, ALL_EN, `RESP_SLVERR);
      rd(12'h300, 32'h0, `RESP_SLVERR);
      // Mid-run reset must drop every enable
      wr(SET, ALL_EN, `RESP_OKAY);
      repeat (2) @(posedge core_clk);
      chk({31'h0, irq}, 32'h1);
      srst <= 1'b1;
      repeat (2) @(posedge core_clk);
      srst <= 1'b0;
      @(posedge core_clk);
      rd(SET, 32'h0, `RESP_OKAY);
      chk({31'h0, irq}, 32'h0);
      print_verdict;
   end
   initial begin
      repeat (5000) @(posedge core_clk);
      failures = failures + 1;
      print_verdict;
   end
endmodule
bind power_event_interrupt_enable power_event_props power_event_props_inst (
   .core_clk(core_clk), .srst(srst), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .irq(irq)
);
